// >>> ocf_fault_limit.sv
// Contract
// - threshold drives channel over-current detector
// - write below warning sets cml, ivd, alert
// - page 0 ch1, 1 ch2, 11 both
// - page 0 always writable; page 1 master-only
// - slave channel 2 uses page 0 value
// - slave page 1 write: nack, invalid command, alert
// - exponent fixed at -1, half amp step
// - writes to read-only bits are discarded
// - exponent in [15:11], mantissa in [10:0]
// - power-up word f83c, 30 A
// - mantissa held between 6 and 100
// - nonvolatile user value replaces power-up default
`timescale 1ns/100ps
module ocf_fault_limit #(
  parameter int MEAS_W    = 16,
  parameter int MEAS_FRAC = 4
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // decoded management-bus command
  input  wire logic                   cmdValid,
  input  wire ocf_pkg::ocf_cmd_t      cmd,
  input  wire logic [7:0]             pageSel,
  output ocf_pkg::ocf_rsp_t           rsp,
  output logic                        rspValid,
  // channel configuration
  input  wire logic                   ch2Slave,
  input  wire logic [1:0][15:0]       warnWord,
  // nonvolatile user defaults
  input  wire logic                   nvmValid,
  input  wire logic [1:0][15:0]       nvmWord,
  input  wire logic                   storeUser,
  input  wire logic                   restoreUser,
  output logic                        nvmWrite,
  output logic [1:0][15:0]            nvmData,
  // measurement and fault reporting
  input  wire logic [1:0][MEAS_W-1:0] measCurrent,
  input  wire logic                   clearFaults,
  output ocf_pkg::ocf_status_t        status,
  output logic                        smbAlert,
  output logic [1:0][15:0]            faultThreshold,
  output wire logic [1:0]             ocFault
);
  import ocf_pkg::*;

  ocf_sel_t              sel;
  logic                  isOurs;
  logic                  isWrite;
  logic                  badPage;
  logic                  slaveHit;
  logic                  reject;
  logic                  doWrite;
  logic [1:0]            hit;
  logic [OCF_MANT_W-1:0] wrMant;
  logic                  anyBelow;
  logic                  belowWarn [2];
  logic [OCF_MANT_W-1:0] mant      [2];
  logic [OCF_MANT_W-1:0] next_mant [2];
  logic [OCF_MANT_W-1:0] next_eff  [2];
  logic                  next_rspValid;
  ocf_rsp_t              next_rsp;
  ocf_status_t           next_status;
  logic                  next_smbAlert;
  logic                  next_nvmWrite;
  logic [1:0][15:0]      next_nvmData;

  // out-of-span values are pinned to the nearest limit
  function automatic logic [OCF_MANT_W-1:0] clampMant(
    input logic [OCF_MANT_W-1:0] m
  );
    logic [OCF_MANT_W-1:0] r;
    r = m;
    if ($signed(m) < $signed(OCF_MANT_MIN))
    begin
      r = OCF_MANT_MIN;
    end
    else if ($signed(m) > $signed(OCF_MANT_MAX))
    begin
      r = OCF_MANT_MAX;
    end
    return r;
  endfunction

  // command decode
  always_comb
  begin
    sel      = ocf_sel_t'({pageSel[OCF_PAGE_HI_BIT],
                           pageSel[OCF_PAGE_LO_BIT]});
    isOurs   = cmdValid && (cmd.code == OCF_CMD_CODE);
    isWrite  = isOurs && cmd.write;
    hit[0]   = (sel == OCF_SEL_CH1) || (sel == OCF_SEL_BOTH);
    hit[1]   = (sel == OCF_SEL_CH2) || (sel == OCF_SEL_BOTH);
    badPage  = (sel == OCF_SEL_BAD);
    slaveHit = hit[1] && ch2Slave;
    // page 11 while slaved is refused whole, so ch1 is never left
    // half-updated by a broadcast that the host believes failed
    reject   = isOurs && (badPage || (cmd.write && slaveHit));
    doWrite  = isWrite && !reject;
    // only the mantissa is taken; the exponent bits are dropped
    wrMant   = clampMant(cmd.data[OCF_MANT_W-1:0]);
  end

  // per-channel threshold state and detector
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_ch
      always_comb
      begin
        // warning word is taken with the same fixed exponent
        belowWarn[g] = doWrite && hit[g] &&
          ($signed(wrMant) <
           $signed(warnWord[g][OCF_MANT_W-1:0]));
        if (srst)
        begin
          next_mant[g] = nvmValid ?
            clampMant(nvmWord[g][OCF_MANT_W-1:0]) :
            OCF_RESET_MANT;
        end
        else if (restoreUser && nvmValid)
        begin
          next_mant[g] = clampMant(nvmWord[g][OCF_MANT_W-1:0]);
        end
        else if (doWrite && hit[g])
        begin
          next_mant[g] = wrMant;
        end
        else
        begin
          next_mant[g] = mant[g];
        end
        if ((g == 1) && ch2Slave)
        begin
          next_eff[g] = next_mant[0];
        end
        else
        begin
          next_eff[g] = next_mant[g];
        end
      end

      ocf_oc_detect #(
        .MANT_W    (OCF_MANT_W),
        .MEAS_W    (MEAS_W),
        .MEAS_FRAC (MEAS_FRAC)
      ) u_detect (
        .clk         (clk),
        .srst        (srst),
        .threshMant  (faultThreshold[g][OCF_MANT_W-1:0]),
        .meas        (measCurrent[g]),
        .overCurrent (ocFault[g])
      );
    end
  endgenerate

  // response, sticky flags, alert and nonvolatile save
  always_comb
  begin
    anyBelow      = belowWarn[0] || belowWarn[1];
    next_rspValid = isOurs && !srst;
    next_rsp.ack  = isOurs && !reject;
    next_rsp.data = 16'h0000;
    if (isOurs && !cmd.write && !badPage)
    begin
      next_rsp.data = (sel == OCF_SEL_CH2) ?
        faultThreshold[1] : faultThreshold[0];
    end
    // a new event wins over a clear in the same cycle
    next_status.cml = anyBelow || reject ||
                      (status.cml && !clearFaults);
    next_status.ivd = anyBelow || (status.ivd && !clearFaults);
    next_status.invalid_command_fault = reject || (status.invalid_command_fault && !clearFaults);
    next_nvmWrite   = storeUser;
    next_nvmData    = nvmData;
    for (int i = 0; i < 2; i++)
    begin
      if (storeUser)
      begin
        next_nvmData[i] = {OCF_EXP, mant[i]};
      end
    end
    if (srst)
    begin
      next_status   = '0;
      next_nvmWrite = 1'b0;
      next_nvmData  = '0;
      next_rsp      = '0;
    end
    next_smbAlert = next_status.cml || next_status.ivd ||
                    next_status.invalid_command_fault;
  end

  always_ff @(posedge clk)
  begin
    rspValid <= next_rspValid;
    rsp      <= next_rsp;
    status   <= next_status;
    smbAlert <= next_smbAlert;
    nvmWrite <= next_nvmWrite;
    nvmData  <= next_nvmData;
    for (int i = 0; i < 2; i++)
    begin
      mant[i]           <= next_mant[i];
      faultThreshold[i] <= {OCF_EXP, next_eff[i]};
    end
  end

  chk_exp_fixed:
    assert property (@(posedge clk) disable iff (srst)
      (faultThreshold[0][OCF_EXP_MSB:OCF_EXP_LSB] == 5'h1f) &&
      (faultThreshold[1][OCF_EXP_MSB:OCF_EXP_LSB] == 5'h1f))
    else $error("exponent field not -1");

  chk_slave_nack:
    assert property (@(posedge clk) disable iff (srst)
      (cmdValid && cmd.write && (cmd.code == 8'h46) && ch2Slave &&
       (pageSel[7] == 1'b0) && (pageSel[0] == 1'b1))
      |=> rspValid && !rsp.ack && status.invalid_command_fault && smbAlert)
    else $error("slave page write not refused");

  chk_slave_keep:
    assert property (@(posedge clk) disable iff (srst)
      (isWrite && slaveHit && !restoreUser)
      |=> (mant[1] == $past(mant[1])) && (mant[0] == $past(mant[0])))
    else $error("slave page write changed a threshold");

  chk_page0_write:
    assert property (@(posedge clk) disable iff (srst)
      (cmdValid && cmd.write && (cmd.code == 8'h46) &&
       (pageSel[7] == 1'b0) && (pageSel[0] == 1'b0) && !restoreUser &&
       ($signed(cmd.data[10:0]) >= 6) && ($signed(cmd.data[10:0]) <= 100))
      |=> rsp.ack ##0 (mant[0] == $past(cmd.data[10:0])))
    else $error("page 0 write not stored");

  chk_mant_range:
    assert property (@(posedge clk) disable iff (srst)
      ($signed(mant[0]) >= 6) && ($signed(mant[0]) <= 100) &&
      ($signed(mant[1]) >= 6) && ($signed(mant[1]) <= 100))
    else $error("mantissa outside 6..100");

  chk_below_warn:
    assert property (@(posedge clk) disable iff (srst)
      (doWrite && hit[0] &&
       ($signed(wrMant) < $signed(warnWord[0][10:0])))
      |=> status.cml && status.ivd && smbAlert)
    else $error("write below warning not flagged");

  chk_slave_share:
    assert property (@(posedge clk) disable iff (srst)
      $past(ch2Slave) |-> (faultThreshold[1] == faultThreshold[0]))
    else $error("slave channel not following page 0");

  chk_both_pages:
    assert property (@(posedge clk) disable iff (srst)
      (doWrite && (sel == OCF_SEL_BOTH) && !restoreUser)
      |=> (mant[0] == mant[1]) && (mant[0] == $past(wrMant)))
    else $error("page 11 write not applied to both");

  chk_reset_word:
    assert property (@(posedge clk)
      ($past(srst) && !$past(nvmValid) && !srst)
      |-> (faultThreshold[0] == 16'hf83c))
    else $error("reset word is not f83c");

  chk_store_user:
    assert property (@(posedge clk) disable iff (srst)
      storeUser |=> nvmWrite && (nvmData[0][10:0] == $past(mant[0])))
    else $error("user save did not capture threshold");

endmodule

// >>> ocf_pkg.sv
package ocf_pkg;

  // management command code of the fault threshold word
  localparam logic [7:0]  OCF_CMD_CODE     = 8'h46;

  // PAGE bits that pick the channel(s)
  localparam int          OCF_PAGE_HI_BIT  = 7;
  localparam int          OCF_PAGE_LO_BIT  = 0;

  // word layout: exponent in [15:11], mantissa in [10:0]
  localparam int          OCF_MANT_W       = 11;
  localparam int          OCF_EXP_LSB      = 11;
  localparam int          OCF_EXP_MSB      = 15;
  localparam logic [4:0]  OCF_EXP          = 5'h1f;

  // value after reset and legal mantissa span
  localparam logic [15:0] OCF_RESET_WORD   = 16'hf83c;
  localparam logic [10:0] OCF_RESET_MANT   = OCF_RESET_WORD[10:0];
  localparam logic [10:0] OCF_MANT_MIN     = 11'h006;
  localparam logic [10:0] OCF_MANT_MAX     = 11'h064;

  // decoded {PAGE[7], PAGE[0]}
  typedef enum logic [1:0] {
    OCF_SEL_CH1  = 2'b00,
    OCF_SEL_CH2  = 2'b01,
    OCF_SEL_BAD  = 2'b10,
    OCF_SEL_BOTH = 2'b11
  } ocf_sel_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } ocf_cmd_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } ocf_rsp_t;

  typedef struct packed {
    logic cml;
    logic ivd;
    logic invalid_command_fault;
  } ocf_status_t;

endpackage

// >>> ocf_oc_detect.sv
`timescale 1ns/100ps
module ocf_oc_detect #(
  parameter int MANT_W    = 11,
  parameter int MEAS_W    = 16,
  parameter int MEAS_FRAC = 4
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // threshold mantissa and measured current
  input  wire logic [MANT_W-1:0] threshMant,
  input  wire logic [MEAS_W-1:0] meas,
  // fault level
  output logic                   overCurrent
);

  logic signed [MEAS_W:0] thrScaled;
  logic signed [MEAS_W:0] measExt;
  logic                   next_overCurrent;

  // one mantissa step is 0.5 A, meas carries MEAS_FRAC fraction bits
  always_comb
  begin
    thrScaled = (MEAS_W+1)'($signed(threshMant));
    thrScaled = thrScaled <<< (MEAS_FRAC - 1);
    measExt   = (MEAS_W+1)'($signed(meas));
    next_overCurrent = !srst && (measExt > thrScaled);
  end

  always_ff @(posedge clk)
  begin
    overCurrent <= next_overCurrent;
  end

  chk_oc_above:
    assert property (@(posedge clk) disable iff (srst)
      (measExt > thrScaled) |=> overCurrent)
    else $error("current above threshold not flagged");

endmodule

// >>> ocf_host_model.sv
`timescale 1ns/100ps
module ocf_host_model (
  // clock
  input  wire logic         clk,
  // command port
  output logic              cmdValid,
  output ocf_pkg::ocf_cmd_t cmd
);
  import ocf_pkg::*;

  initial
  begin
    cmdValid = 1'b0;
    cmd      = '0;
  end

  // one command per call, returns at the answer edge; the idle bus shows
  // inverted data so a design that samples it late sees garbage
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data);
    cmdValid <= 1'b1;
    cmd      <= '{write: wr, code: code, data: data};
    @(posedge clk);
    cmdValid <= 1'b0;
    cmd      <= '{write: ~wr, code: ~code, data: ~data};
    @(posedge clk);
  endtask
endmodule

// >>> ocf_fault_limit_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin checksDone++; if ((got) !== (exp)) begin errorCnt++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); end end
module ocf_fault_limit_tb;
  import ocf_pkg::*;
  logic               clk, srst, cmdValid, rspValid, ch2Slave, nvmValid;
  logic               storeUser, restoreUser, nvmWrite, clearFaults, smbAlert;
  logic [7:0]         pageSel;
  logic [1:0][15:0]   warnWord, nvmWord, nvmData, faultThreshold, measCurrent;
  logic [1:0]         ocFault;
  ocf_cmd_t           cmd;
  ocf_rsp_t           rsp;
  ocf_status_t        status;
  int                 errorCnt, checksDone, seed;
  logic [17:0]        expQ[$];
  logic [17:0]        e;
  logic [10:0]        m;

  ocf_host_model host (.clk(clk), .cmdValid(cmdValid), .cmd(cmd));
  ocf_fault_limit DUT (.clk(clk), .srst(srst), .cmdValid(cmdValid),
    .cmd(cmd), .pageSel(pageSel), .rsp(rsp), .rspValid(rspValid),
    .ch2Slave(ch2Slave), .warnWord(warnWord), .nvmValid(nvmValid),
    .nvmWord(nvmWord), .storeUser(storeUser), .restoreUser(restoreUser),
    .nvmWrite(nvmWrite), .nvmData(nvmData), .measCurrent(measCurrent),
    .clearFaults(clearFaults), .status(status), .smbAlert(smbAlert),
    .faultThreshold(faultThreshold), .ocFault(ocFault));

  always #12.5 clk = ~clk;

  // answers are matched in order against the notes left by the driver
  always @(posedge clk)
    if (rspValid === 1'b1)
    begin
      // an answer with no note behind it is always a mismatch
      if (expQ.size() == 0)
        `CHK(rspValid, 1'b0)
      else
      begin
        e = expQ.pop_front();
        `CHK(rsp.ack, e[16])
        if (e[17] === 1'b1)
          `CHK(rsp.data, e[15:0])
      end
    end

  task automatic access(input logic wr, input logic [7:0] page,
                        input logic [15:0] d, input logic [17:0] ex);
    expQ.push_back(ex);
    pageSel <= page;
    host.xfer(wr, OCF_CMD_CODE, d);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(25 * 4000);
    errorCnt++;
    complete_run();
  end

  initial
  begin
    clk = 1'b0; srst = 1'b1; pageSel = '0; ch2Slave = 1'b0;
    warnWord = '0; nvmValid = 1'b0; nvmWord = '0; storeUser = 1'b0;
    restoreUser = 1'b0; measCurrent = '0; clearFaults = 1'b0;
    seed = $urandom(90562);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    access(1'b0, 8'h00, '0, {2'b11, OCF_RESET_WORD});
    access(1'b0, 8'h01, '0, {2'b11, OCF_RESET_WORD});
    $display("test reset done");
    // host stays inside the legal mantissa span, both ends included
    for (int i = 0; i < 6; i++)
    begin
      m = (i == 0) ? 11'h006 : (i == 1) ? 11'h064 : 11'(6 + $urandom % 95);
      access(1'b1, 8'h00, {5'($urandom), m}, 18'h10000);
      access(1'b0, 8'h00, '0, {2'b11, OCF_EXP, m});
    end
    $display("test layout done");
    access(1'b1, 8'h81, {5'h00, 11'h050}, 18'h10000);
    access(1'b0, 8'h00, '0, {2'b11, 16'hf850});
    access(1'b0, 8'h01, '0, {2'b11, 16'hf850});
    $display("test both pages done");
    warnWord[0] <= 16'hf85a;
    access(1'b1, 8'h00, 16'hf850, 18'h10000);
    @(negedge clk);
    `CHK({status.cml, status.ivd, smbAlert}, 3'b111)
    @(posedge clk);
    clearFaults <= 1'b1;
    warnWord[0] <= 16'hf840;
    @(posedge clk);
    clearFaults <= 1'b0;
    @(negedge clk);
    `CHK(smbAlert, 1'b0)
    $display("test warning done");
    @(posedge clk);
    access(1'b1, 8'h01, 16'hf848, 18'h10000);
    access(1'b0, 8'h01, '0, {2'b11, 16'hf848});
    ch2Slave <= 1'b1;
    access(1'b1, 8'h01, 16'hf864, 18'h00000);
    @(negedge clk);
    `CHK({status.invalid_command_fault, smbAlert}, 2'b11)
    `CHK(faultThreshold[1], 16'hf850)
    @(posedge clk);
    access(1'b0, 8'h01, '0, {2'b11, 16'hf850});
    clearFaults <= 1'b1;
    ch2Slave <= 1'b0;
    @(posedge clk);
    clearFaults <= 1'b0;
    $display("test slave done");
    // 0x50 half amperes is 640 sixteenths, 0x48 is 576; each channel
    // trips one sixteenth above its own threshold only
    measCurrent <= {16'd576, 16'd641};
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(ocFault, 2'b01)
    @(posedge clk);
    measCurrent <= {16'd577, 16'd640};
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(ocFault, 2'b10)
    $display("test detector done");
    @(posedge clk);
    storeUser <= 1'b1;
    @(posedge clk);
    storeUser <= 1'b0;
    @(negedge clk);
    `CHK({nvmWrite, nvmData[0]}, {1'b1, 16'hf850})
    `CHK(nvmData[1], 16'hf848)
    $display("test store done");
    // invalid page is refused; a foreign code must get no answer
    @(posedge clk);
    access(1'b0, 8'h80, '0, 18'h00000);
    host.xfer(1'b1, 8'h47, 16'hf806);
    @(negedge clk);
    `CHK({status.cml, status.invalid_command_fault, smbAlert}, 3'b111)
    @(posedge clk);
    access(1'b0, 8'h00, '0, {2'b11, 16'hf850});
    $display("test refuse done");
    clearFaults <= 1'b1;
    nvmValid    <= 1'b1;
    nvmWord     <= {16'hf80a, 16'hf8c8};
    @(posedge clk);
    clearFaults <= 1'b0;
    restoreUser <= 1'b1;
    @(posedge clk);
    restoreUser <= 1'b0;
    access(1'b0, 8'h00, '0, {2'b11, 16'hf864});
    access(1'b0, 8'h01, '0, {2'b11, 16'hf80a});
    $display("test restore done");
    // a mid-run reset must reload the saved words, not the default
    srst       <= 1'b1;
    nvmWord[0] <= 16'hf814;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    access(1'b0, 8'h00, '0, {2'b11, 16'hf814});
    access(1'b0, 8'h01, '0, {2'b11, 16'hf80a});
    `CHK(status, 3'b000)
    $display("test reload done");
    repeat (3) @(posedge clk);
    `CHK(expQ.size(), 0)
    complete_run();
  end
endmodule
